// file: flash_sp_pkg.sv
// Functional notes
// - low-word table read and write reach bits 15:0, word or byte mode
// - high table read and write reach bits 23:16, word or byte mode
// - address joins table page bits 7:0 with the 16-bit effective address
// - row is 32 instructions (96 bytes), panel 128 rows; erase one row
// - 32 write latches per panel, filled in order inside one aligned group
// - table write only updates latches: one word, two cycles, no program
// - one programming cycle per row; latches reach flash only when started
// - address low captures ea 15:0 of last table instruction, picks row
// - address high captures address bits 23:16 of the last table instruction
// - address low and high registers accept direct software writes
// - key register write-only; 0x55 then 0xaa must precede any operation
// - operation lasts nominally 2 ms; processor stalls until it finishes
// - start bit 15 launches the operation; hardware clears it when done
// - fill 32 latches, set program, unlock, start; device writes whole row
// - control selects erase blocks, memory type, and holds the start bit
package flash_sp_pkg;
  localparam int AXI_ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;
  localparam int REG_W = 16;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ADDR_LOW = 8'h04;
  localparam logic [7:0] OFF_ADDR_HIGH = 8'h08;
  localparam logic [7:0] OFF_KEY = 8'h0c;
  localparam logic [7:0] OFF_PAGE = 8'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CTRL_START_BIT = 15;
  localparam int CTRL_FLASH_WRITE_ENABLE_BIT_BIT = 14;
  localparam int OP_W = 7;
  localparam logic [6:0] OP_ERASE_ROW = 7'h41;
  localparam logic [6:0] OP_PROG_ROW = 7'h01;
  localparam logic [6:0] OP_RESET = 7'h00;
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  localparam int WORD_W = 24;
  localparam int EA_W = 16;
  localparam int PAGE_W = 8;
  localparam int ROW_WORDS = 32;
  localparam int ROW_BYTES = 96;
  localparam int PANEL_ROWS = 128;
  localparam int IDX_W = 5;
  localparam int ROW_LSB = 6;
  localparam int ROW_W = WORD_W - ROW_LSB;
  localparam logic [4:0] IDX_LAST = 5'h1f;
  localparam logic [23:0] LATCH_RESET = 24'hffffff;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [7:0] PAGE_RESET = 8'h00;
  localparam int unsigned OP_TIME_MS = 2;
  localparam int unsigned CLK_FREQ_HZ = 250_000_000;
  localparam int unsigned OP_CYCLES = OP_TIME_MS * (CLK_FREQ_HZ / 1000);
  localparam int unsigned TBL_CYCLES = 2;
endpackage

// file: op_timer.sv
`timescale 1ns/1ps
`default_nettype none
module op_timer #(
  parameter int unsigned COUNT = 4
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic start,
  output logic busy
);
  localparam int CNT_W = $clog2(COUNT + 1);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic busy_d;

  // busy stays high for exactly COUNT cycles after the start edge
  always_comb begin
    cnt_d = cnt_q;
    if (start) begin
      cnt_d = CNT_W'(COUNT);
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - 1'b1;
    end
    busy_d = (cnt_d != '0);
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cnt_q <= '0;
      busy <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      busy <= busy_d;
    end
  end
endmodule
`default_nettype wire

// file: flash_self_program.sv
`timescale 1ns/1ps
`default_nettype none
module flash_self_program #(
  parameter int unsigned OP_CYCLES = flash_sp_pkg::OP_CYCLES
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [flash_sp_pkg::AXI_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [flash_sp_pkg::DATA_W-1:0] wdata,
  input wire logic [flash_sp_pkg::STRB_W-1:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [flash_sp_pkg::AXI_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [flash_sp_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic tbl_req,
  input wire logic tbl_write,
  input wire logic tbl_high,
  input wire logic tbl_byte,
  input wire logic [flash_sp_pkg::EA_W-1:0] tbl_ea,
  input wire logic [flash_sp_pkg::EA_W-1:0] tbl_wdata,
  output logic [flash_sp_pkg::EA_W-1:0] tbl_rdata,
  output logic tbl_done,
  output logic cpu_stall,
  output logic [flash_sp_pkg::WORD_W-1:0] flash_rd_addr,
  input wire logic [flash_sp_pkg::WORD_W-1:0] flash_rd_data,
  output logic flash_erase,
  output logic flash_wr_valid,
  output logic [flash_sp_pkg::WORD_W-1:0] flash_addr,
  output logic [flash_sp_pkg::WORD_W-1:0] flash_wr_data
);
  import flash_sp_pkg::*;

  typedef enum logic [2:0] {
    KEY_IDLE = 3'b001, KEY_HALF = 3'b010, KEY_ARMED = 3'b100
  } key_state_t;
  typedef enum logic [2:0] {
    OP_IDLE = 3'b001, OP_STREAM = 3'b010, OP_WAIT = 3'b100
  } op_state_t;
  typedef enum logic [1:0] {TB_IDLE = 2'b01, TB_ACT = 2'b10} tbl_state_t;

  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [AXI_ADDR_W-1:0] waddr_q, waddr_d;
  logic [DATA_W-1:0] wdata_q, wdata_d, rdata_d;
  logic [STRB_W-1:0] wstrb_q, wstrb_d;
  logic awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
  logic [1:0] bresp_d, rresp_d;
  logic wr_fire, ar_fire, wr_hit, rd_hit;
  logic [7:0] wsel, rsel;
  logic [REG_W-1:0] rd_val, mask16, ctrl_rd, ctrl_new;
  logic start_q, start_d, flash_write_enable_bit_q, flash_write_enable_bit_d;
  logic [OP_W-1:0] op_q, op_d;
  logic [REG_W-1:0] addr_low_q, addr_low_d, addr_high_q, addr_high_d;
  logic [PAGE_W-1:0] page_q, page_d;
  key_state_t key_q, key_d;
  logic ctrl_wr, op_ok, launch;
  op_state_t opst_q, opst_d;
  logic [IDX_W-1:0] idx_q, idx_d;
  logic [ROW_W-1:0] row_q, row_d;
  logic erase_d, wr_valid_d, stall_d, tmr_busy;
  logic [WORD_W-1:0] faddr_d, fdata_d;
  tbl_state_t tb_q, tb_d;
  logic tb_write_q, tb_write_d, tb_high_q, tb_high_d;
  logic tb_byte_q, tb_byte_d, tb_odd_q, tb_odd_d;
  logic tbl_take, done_d;
  logic [EA_W-1:0] trdata_d;
  logic [WORD_W-1:0] rd_addr_d;
  logic [WORD_W-1:0] latch_q [ROW_WORDS];
  logic [IDX_W-1:0] lat_idx;
  logic [WORD_W-1:0] lat_new;
  logic lat_we;

  //////////////////////////////////////////////////////////////////////////
  // register bus slave

  assign wr_fire = aw_have_q && w_have_q && !bvalid;
  assign ar_fire = arvalid && arready;
  assign wsel = {waddr_q[AXI_ADDR_W-1:2], 2'b00};
  assign rsel = {araddr[AXI_ADDR_W-1:2], 2'b00};
  assign wr_hit = (wsel == OFF_CTRL) || (wsel == OFF_ADDR_LOW) ||
                  (wsel == OFF_ADDR_HIGH) || (wsel == OFF_KEY) ||
                  (wsel == OFF_PAGE);

  always_comb begin
    rd_hit = 1'b1;
    rd_val = REG_RESET;
    unique case (rsel)
      OFF_CTRL: rd_val = ctrl_rd;
      OFF_ADDR_LOW: rd_val = addr_low_q;
      OFF_ADDR_HIGH: rd_val = addr_high_q;
      // the key never reads back, so software cannot learn it from a dump
      OFF_KEY: rd_val = REG_RESET;
      OFF_PAGE: rd_val = {8'h00, page_q};
      default: rd_hit = 1'b0;
    endcase
  end

  always_comb begin
    aw_have_d = aw_have_q;
    waddr_d = waddr_q;
    w_have_d = w_have_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    if (aw_have_q) begin
      if (wr_fire) aw_have_d = 1'b0;
    end else if (awvalid && awready) begin
      aw_have_d = 1'b1;
      waddr_d = awaddr;
    end
    if (w_have_q) begin
      if (wr_fire) w_have_d = 1'b0;
    end else if (wvalid && wready) begin
      w_have_d = 1'b1;
      wdata_d = wdata;
      wstrb_d = wstrb;
    end
    awready_d = !aw_have_d;
    wready_d = !w_have_d;
    bvalid_d = bvalid;
    bresp_d = bresp;
    if (wr_fire) begin
      bvalid_d = 1'b1;
      bresp_d = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid && bready) begin
      bvalid_d = 1'b0;
    end
    rvalid_d = rvalid;
    rdata_d = rdata;
    rresp_d = rresp;
    if (ar_fire) begin
      rvalid_d = 1'b1;
      rdata_d = {16'h0000, rd_val};
      rresp_d = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid_d = 1'b0;
    end
    arready_d = !rvalid_d;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      waddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      awready <= awready_d;
      wready <= wready_d;
      bvalid <= bvalid_d;
      bresp <= bresp_d;
      arready <= arready_d;
      rvalid <= rvalid_d;
      rdata <= rdata_d;
      rresp <= rresp_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // control, address, page and unlock key

  assign mask16 = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign ctrl_rd = {start_q, flash_write_enable_bit_q, 7'h00, op_q};
  assign ctrl_new = (ctrl_rd & ~mask16) | (wdata_q[REG_W-1:0] & mask16);
  assign ctrl_wr = wr_fire && (wsel == OFF_CTRL);
  assign op_ok = (ctrl_new[OP_W-1:0] == OP_ERASE_ROW) ||
                 (ctrl_new[OP_W-1:0] == OP_PROG_ROW);
  // start gated by key and enable
  assign launch = ctrl_wr && ctrl_new[CTRL_START_BIT] && !start_q &&
                  ctrl_new[CTRL_FLASH_WRITE_ENABLE_BIT_BIT] && op_ok &&
                  (key_q == KEY_ARMED) && (opst_q == OP_IDLE);

  always_comb begin
    start_d = start_q;
    flash_write_enable_bit_d = flash_write_enable_bit_q;
    op_d = op_q;
    addr_low_d = addr_low_q;
    addr_high_d = addr_high_q;
    page_d = page_q;
    key_d = key_q;
    if (tbl_take) begin
      addr_low_d = tbl_ea;
      addr_high_d = {8'h00, page_q};
    end else if (wr_fire) begin
      if (wsel == OFF_ADDR_LOW) begin
        addr_low_d = (addr_low_q & ~mask16) | (wdata_q[REG_W-1:0] & mask16);
      end
      if ((wsel == OFF_ADDR_HIGH) && wstrb_q[0]) begin
        addr_high_d = {8'h00, wdata_q[PAGE_W-1:0]};
      end
    end
    if (wr_fire && (wsel == OFF_PAGE) && wstrb_q[0]) begin
      page_d = wdata_q[PAGE_W-1:0];
    end
    // selection is frozen while an operation runs
    if (ctrl_wr && !start_q) begin
      flash_write_enable_bit_d = ctrl_new[CTRL_FLASH_WRITE_ENABLE_BIT_BIT];
      op_d = ctrl_new[OP_W-1:0];
    end
    if (launch) begin
      start_d = 1'b1;
    end else if ((opst_q == OP_WAIT) && !tmr_busy) begin
      start_d = 1'b0;
    end
    if (wr_fire) begin
      if ((wsel == OFF_KEY) && wstrb_q[0]) begin
        if (wdata_q[7:0] == KEY_FIRST) begin
          key_d = KEY_HALF;
        end else if ((wdata_q[7:0] == KEY_SECOND) && (key_q == KEY_HALF)) begin
          key_d = KEY_ARMED;
        end else begin
          key_d = KEY_IDLE;
        end
      end else begin
        key_d = KEY_IDLE;
      end
    end
    // a table write in the same cycle as a key write still disarms
    if (tbl_take && tbl_write) begin
      key_d = KEY_IDLE;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      start_q <= 1'b0;
      flash_write_enable_bit_q <= 1'b0;
      op_q <= OP_RESET;
      addr_low_q <= REG_RESET;
      addr_high_q <= REG_RESET;
      page_q <= PAGE_RESET;
      key_q <= KEY_IDLE;
    end else begin
      start_q <= start_d;
      flash_write_enable_bit_q <= flash_write_enable_bit_d;
      op_q <= op_d;
      addr_low_q <= addr_low_d;
      addr_high_q <= addr_high_d;
      page_q <= page_d;
      key_q <= key_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // erase and program sequencer

  op_timer #(.COUNT(OP_CYCLES)) u_timer (
    .mclk(mclk),
    .reset(reset),
    .start(launch),
    .busy(tmr_busy)
  );

  always_comb begin
    opst_d = opst_q;
    idx_d = idx_q;
    row_d = row_q;
    erase_d = 1'b0;
    wr_valid_d = 1'b0;
    faddr_d = flash_addr;
    fdata_d = flash_wr_data;
    unique case (opst_q)
      OP_IDLE: begin
        if (launch) begin
          row_d = {addr_high_q[PAGE_W-1:0], addr_low_q[EA_W-1:ROW_LSB]};
          idx_d = '0;
          if (ctrl_new[OP_W-1:0] == OP_ERASE_ROW) begin
            erase_d = 1'b1;
            faddr_d = {row_d, 6'h00};
            opst_d = OP_WAIT;
          end else begin
            opst_d = OP_STREAM;
          end
        end
      end
      OP_STREAM: begin
        wr_valid_d = 1'b1;
        faddr_d = {row_q, idx_q, 1'b0};
        fdata_d = latch_q[idx_q];
        idx_d = idx_q + 5'h01;
        if (idx_q == IDX_LAST) opst_d = OP_WAIT;
      end
      OP_WAIT: begin
        if (!tmr_busy) opst_d = OP_IDLE;
      end
      default: opst_d = OP_IDLE;
    endcase
    stall_d = (opst_d != OP_IDLE);
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      opst_q <= OP_IDLE;
      idx_q <= '0;
      row_q <= '0;
      flash_erase <= 1'b0;
      flash_wr_valid <= 1'b0;
      flash_addr <= '0;
      flash_wr_data <= '0;
      cpu_stall <= 1'b0;
    end else begin
      opst_q <= opst_d;
      idx_q <= idx_d;
      row_q <= row_d;
      flash_erase <= erase_d;
      flash_wr_valid <= wr_valid_d;
      flash_addr <= faddr_d;
      flash_wr_data <= fdata_d;
      cpu_stall <= stall_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // table instructions and write latches

  // a stalled core issues nothing, so no table access during an operation
  assign tbl_take = tbl_req && (tb_q == TB_IDLE) && !tbl_done &&
                    (opst_q == OP_IDLE);
  assign lat_idx = tbl_ea[ROW_LSB-1:1];
  assign lat_we = tbl_take && tbl_write;

  always_comb begin
    lat_new = latch_q[lat_idx];
    if (tbl_high) begin
      if (!(tbl_byte && tbl_ea[0])) lat_new[23:16] = tbl_wdata[7:0];
    end else if (tbl_byte) begin
      if (tbl_ea[0]) lat_new[15:8] = tbl_wdata[7:0];
      else lat_new[7:0] = tbl_wdata[7:0];
    end else begin
      lat_new[15:0] = tbl_wdata;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < ROW_WORDS; i++) latch_q[i] <= LATCH_RESET;
    end else if (lat_we) begin
      latch_q[lat_idx] <= lat_new;
    end
  end

  always_comb begin
    tb_d = tb_q;
    done_d = 1'b0;
    trdata_d = tbl_rdata;
    rd_addr_d = flash_rd_addr;
    tb_write_d = tb_write_q;
    tb_high_d = tb_high_q;
    tb_byte_d = tb_byte_q;
    tb_odd_d = tb_odd_q;
    unique case (tb_q)
      TB_IDLE: begin
        if (tbl_take) begin
          tb_d = TB_ACT;
          tb_write_d = tbl_write;
          tb_high_d = tbl_high;
          tb_byte_d = tbl_byte;
          tb_odd_d = tbl_ea[0];
          rd_addr_d = {page_q, tbl_ea};
        end
      end
      TB_ACT: begin
        tb_d = TB_IDLE;
        done_d = 1'b1;
        if (!tb_write_q) begin
          if (tb_high_q) begin
            trdata_d = (tb_byte_q && tb_odd_q) ? 16'h0000 :
                       {8'h00, flash_rd_data[23:16]};
          end else if (tb_byte_q) begin
            trdata_d = {8'h00, tb_odd_q ? flash_rd_data[15:8] :
                        flash_rd_data[7:0]};
          end else begin
            trdata_d = flash_rd_data[15:0];
          end
        end
      end
      default: tb_d = TB_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      tb_q <= TB_IDLE;
      tbl_done <= 1'b0;
      tbl_rdata <= '0;
      flash_rd_addr <= '0;
      tb_write_q <= 1'b0;
      tb_high_q <= 1'b0;
      tb_byte_q <= 1'b0;
      tb_odd_q <= 1'b0;
    end else begin
      tb_q <= tb_d;
      tbl_done <= done_d;
      tbl_rdata <= trdata_d;
      flash_rd_addr <= rd_addr_d;
      tb_write_q <= tb_write_d;
      tb_high_q <= tb_high_d;
      tb_byte_q <= tb_byte_d;
      tb_odd_q <= tb_odd_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks

  int unsigned run_len_q;
  logic [6:0] wr_cnt_q;
  logic was_prog_q;
  logic [7:0] tbl_wbyte;
  assign tbl_wbyte = tbl_wdata[7:0];

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      run_len_q <= 0;
      wr_cnt_q <= '0;
      was_prog_q <= 1'b0;
    end else begin
      run_len_q <= launch ? 0 : (cpu_stall ? run_len_q + 1 : run_len_q);
      if (launch) begin
        wr_cnt_q <= '0;
        was_prog_q <= (ctrl_new[OP_W-1:0] == OP_PROG_ROW);
      end else if (flash_wr_valid) begin
        wr_cnt_q <= wr_cnt_q + 7'h01;
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  AST_LOW_WRITE: assert property (lat_we && !tbl_high && !tbl_byte |=>
    latch_q[$past(lat_idx)][15:0] == $past(tbl_wdata))
    else $error("low word latch write wrong");
  AST_HIGH_WRITE: assert property (lat_we && tbl_high && !tbl_byte |=>
    latch_q[$past(lat_idx)][23:16] == $past(tbl_wbyte))
    else $error("high byte latch write wrong");
  AST_PAGE_ADDR: assert property (tbl_take |=>
    flash_rd_addr == {$past(page_q), $past(tbl_ea)})
    else $error("program address not page joined with ea");
  AST_ERASE_ROW: assert property (flash_erase |->
    flash_addr[5:0] == 6'h00 && !flash_wr_valid ##1 !flash_erase)
    else $error("erase not a single aligned row");
  AST_TBL_TWO_CYCLE: assert property (tbl_take |=> !tbl_done ##1
    tbl_done && !flash_wr_valid && !flash_erase ##1 !tbl_done)
    else $error("table access not two cycles");
  AST_ROW_COUNT: assert property ($fell(cpu_stall) && was_prog_q |->
    wr_cnt_q == 7'd32)
    else $error("program did not write a full row");
  AST_LATCH_ONLY_RUN: assert property (flash_wr_valid |-> cpu_stall)
    else $error("latch data left without an operation");
  AST_CAPTURE_LOW: assert property (tbl_take |=>
    addr_low_q == $past(tbl_ea))
    else $error("address low not captured");
  AST_CAPTURE_HIGH: assert property (tbl_take |=>
    addr_high_q[7:0] == $past(page_q) && addr_high_q[15:8] == 8'h00)
    else $error("address high not captured");
  AST_KEY_GATE: assert property ($rose(start_q) |->
    $past(key_q) == KEY_ARMED && key_q == KEY_IDLE)
    else $error("operation started without unlock");
  AST_FLASH_WRITE_ENABLE_BIT_GATE: assert property ($rose(start_q) |-> flash_write_enable_bit_q)
    else $error("operation started without write enable");
  AST_STALL_LEN: assert property ($fell(cpu_stall) |->
    run_len_q == OP_CYCLES + 1)
    else $error("stall length wrong");
  AST_START_TRACK: assert property (start_q == cpu_stall)
    else $error("start bit and stall disagree");

  COV_ERASE: cover property (flash_erase ##[1:8] cpu_stall);
  COV_PROGRAM: cover property ($fell(cpu_stall) && was_prog_q);
  COV_TBL_READ: cover property (tbl_take && !tbl_write ##1 tbl_done);
endmodule
`default_nettype wire

// file: flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module flash_model (
  input wire logic mclk,
  input wire logic [23:0] rd_addr,
  output logic [23:0] rd_data,
  input wire logic erase,
  input wire logic wr_valid,
  input wire logic [23:0] addr,
  input wire logic [23:0] wr_data
);
  logic [23:0] mem [0:63];
  int erase_n;
  int wr_n;
  // only two rows modelled: address bit 6 picks the row
  initial begin
    erase_n = 0;
    wr_n = 0;
    for (int i = 0; i < 64; i++) mem[i] = {8'h5a, i[7:0], i[7:0]};
  end
  assign rd_data = mem[rd_addr[6:1]];
  always @(posedge mclk) begin
    if (erase === 1'b1) begin
      erase_n++;
      for (int i = 0; i < 32; i++) mem[{addr[6], i[4:0]}] = 24'hffffff;
    end
    if (wr_valid === 1'b1) begin
      wr_n++;
      mem[addr[6:1]] = wr_data;
    end
  end
endmodule
`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import flash_sp_pkg::*;
  localparam int unsigned OPC = 40;
  logic mclk, reset, awvalid, wvalid, bready, arvalid, rready, awready;
  logic wready, bvalid, arready, rvalid, tbl_req, tbl_write, tbl_high;
  logic tbl_byte, tbl_done, cpu_stall, flash_erase, flash_wr_valid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  logic [15:0] tbl_ea, tbl_wdata, tbl_rdata, td;
  logic [23:0] flash_rd_addr, flash_rd_data, flash_addr, flash_wr_data;
  logic [31:0] rv;
  int fail_count, n_tests, stall_n;
  flash_self_program #(.OP_CYCLES(OPC)) u_flash_self_program (.mclk(mclk),
    .reset(reset), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .tbl_req(tbl_req),
    .tbl_write(tbl_write), .tbl_high(tbl_high), .tbl_byte(tbl_byte),
    .tbl_ea(tbl_ea), .tbl_wdata(tbl_wdata), .tbl_rdata(tbl_rdata),
    .tbl_done(tbl_done), .cpu_stall(cpu_stall),
    .flash_rd_addr(flash_rd_addr), .flash_rd_data(flash_rd_data),
    .flash_erase(flash_erase), .flash_wr_valid(flash_wr_valid),
    .flash_addr(flash_addr), .flash_wr_data(flash_wr_data));
  flash_model u_flash_model (.mclk(mclk), .rd_addr(flash_rd_addr),
    .rd_data(flash_rd_data), .erase(flash_erase), .wr_valid(flash_wr_valid),
    .addr(flash_addr), .wr_data(flash_wr_data));
  always #2 mclk = ~mclk;
  always @(negedge mclk) if (cpu_stall === 1'b1) stall_n++;
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] e, input logic [31:0] g,
                     input string n);
    n_tests++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    tb = 0;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!tb) begin
      @(negedge mclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      rs = bresp;
      @(posedge mclk);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
      if (tb) bready <= 0;
    end
  endtask
  task automatic rd(input logic [7:0] a);
    logic ta, tr;
    tr = 0;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    while (!tr) begin
      @(negedge mclk);
      ta = arvalid & arready;
      tr = rvalid;
      rv = rdata;
      rs = rresp;
      @(posedge mclk);
      if (ta) arvalid <= 0;
      if (tr) rready <= 0;
    end
  endtask
  task automatic tbl(input logic w, input logic h, input logic [15:0] ea,
                     input logic [15:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    tbl_req <= 1;
    tbl_write <= w;
    tbl_high <= h;
    tbl_ea <= ea;
    tbl_wdata <= d;
    do begin
      @(negedge mclk);
      n++;
    end while (tbl_done !== 1'b1 && n < 50);
    td = tbl_rdata;
    @(posedge mclk);
    tbl_req <= 0;
    // one cycle presents the request, then the access takes its two
    chk(TBL_CYCLES + 1, n, "table cycles");
  endtask
  task automatic unlock_start(input logic [15:0] c);
    wr(OFF_KEY, 32'h55);
    wr(OFF_KEY, 32'haa);
    stall_n = 0;
    wr(OFF_CTRL, {16'h0, c});
    repeat (2) @(posedge mclk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    wr(OFF_ADDR_LOW, 32'h1234);
    chk(RESP_OKAY, rs, "mapped write");
    rd(OFF_ADDR_LOW);
    chk(32'h1234, rv, "address low");
    wstrb <= 4'h1;
    wr(OFF_ADDR_LOW, 32'h00cd);
    wstrb <= 4'hf;
    rd(OFF_ADDR_LOW);
    chk(32'h12cd, rv, "address low lane");
    wr(OFF_ADDR_HIGH, 32'h00ab);
    rd(OFF_ADDR_HIGH);
    chk(32'hab, rv, "address high");
    wr(OFF_KEY, 32'h55);
    rd(OFF_KEY);
    chk(32'h0, rv, "key read");
    wr(8'h20, 32'h1);
    chk(RESP_SLVERR, rs, "unmapped write");
    rd(8'h20);
    chk(RESP_SLVERR, rs, "unmapped read");
  endtask
  task automatic t_table;
    wr(OFF_PAGE, 32'h3c);
    tbl(1, 0, 16'h0042, 16'hbeef);
    chk(0, u_flash_model.wr_n, "no programming");
    rd(OFF_ADDR_LOW);
    chk(32'h42, rv, "captured low");
    rd(OFF_ADDR_HIGH);
    chk(32'h3c, rv, "captured high");
    tbl(0, 0, 16'h0004, 16'h0);
    chk(32'h0202, td, "read low word");
    chk(32'h3c0004, flash_rd_addr, "read address");
    tbl(0, 1, 16'h0004, 16'h0);
    chk(32'h005a, td, "read high byte");
  endtask
  task automatic t_nokey;
    stall_n = 0;
    wr(OFF_CTRL, 32'hc041);
    wr(OFF_KEY, 32'h55);
    wr(OFF_ADDR_LOW, 32'h40);
    wr(OFF_KEY, 32'haa);
    wr(OFF_CTRL, 32'hc041);
    wr(OFF_KEY, 32'h55);
    wr(OFF_KEY, 32'haa);
    wr(OFF_CTRL, 32'h8041);
    repeat (5) @(posedge mclk);
    chk(0, stall_n, "stall without unlock");
    rd(OFF_CTRL);
    chk(32'h0041, rv, "start ignored");
  endtask
  task automatic t_erase;
    wr(OFF_CTRL, 32'h4041);
    wr(OFF_ADDR_HIGH, 32'h0);
    wr(OFF_ADDR_LOW, 32'h0040);
    unlock_start(16'hc041);
    rd(OFF_CTRL);
    chk(32'hc041, rv, "start while busy");
    repeat (OPC + 20) @(posedge mclk);
    chk(OPC + 1, stall_n, "erase stall");
    rd(OFF_CTRL);
    chk(32'h4041, rv, "start cleared");
    chk(1, u_flash_model.erase_n, "erase count");
    chk(24'hffffff, u_flash_model.mem[45], "erased word");
    chk(24'h5a0505, u_flash_model.mem[5], "other row");
  endtask
  task automatic t_prog;
    wr(OFF_PAGE, 32'h0);
    for (int i = 0; i < 32; i++) begin
      tbl(1, 0, 16'(2 * i), 16'h1000 + 16'(i));
      tbl(1, 1, 16'(2 * i), 16'h0080 + 16'(i));
    end
    chk(0, u_flash_model.wr_n, "latched only");
    wr(OFF_CTRL, 32'h4001);
    unlock_start(16'hc001);
    repeat (OPC + 20) @(posedge mclk);
    chk(OPC + 1, stall_n, "program stall");
    chk(32, u_flash_model.wr_n, "row words");
    chk(24'h9f101f, u_flash_model.mem[31], "last word");
    tbl(0, 0, 16'h000a, 16'h0);
    chk(32'h1005, td, "program low");
    tbl(0, 1, 16'h000a, 16'h0);
    chk(32'h0085, td, "program high");
    // byte mode picks one lane by the address bit 0
    tbl_byte <= 1;
    tbl(0, 0, 16'h000b, 16'h0);
    chk(32'h0010, td, "odd byte low");
    tbl(0, 0, 16'h000a, 16'h0);
    chk(32'h0005, td, "even byte low");
    tbl(0, 1, 16'h000a, 16'h0);
    chk(32'h0085, td, "even byte high");
    tbl_byte <= 0;
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 0;
    reset = 1;
    fail_count = 0;
    n_tests = 0;
    stall_n = 0;
    awaddr = 0;
    awvalid = 0;
    wdata = 0;
    wstrb = 4'hf;
    wvalid = 0;
    bready = 0;
    araddr = 0;
    arvalid = 0;
    rready = 0;
    tbl_req = 0;
    tbl_write = 0;
    tbl_high = 0;
    tbl_byte = 0;
    tbl_ea = 0;
    tbl_wdata = 0;
    repeat (10) @(posedge mclk);
    reset <= 0;
    repeat (2) @(posedge mclk);
    t_regs();
    t_table();
    t_nokey();
    t_erase();
    t_prog();
    stop_test();
  end
  // generous bound: whole run is a few hundred cycles
  initial begin
    #80000;
    fail_count++;
    stop_test();
  end
endmodule
`default_nettype wire
